// File: hdl/ssp_pkg.sv
package ssp_pkg;
  // Command frame layout on the serial link.
  localparam int          FRAME_BITS = 32;
  localparam int          ADDR_W     = 7;
  localparam int          DATA_W     = 24;
  localparam int          ADDR_MSB   = 31;
  localparam int          ADDR_LSB   = 25;
  localparam int          RW_BIT     = 24;
  localparam int          FAULT_BIT  = 23;
  localparam int          INT_BIT    = 22;
  localparam int          REGD_W     = 22;
  localparam int          CNT_W      = 6;
  localparam logic [5:0]  FRAME_CNT  = 6'h20;

  // Input groups.
  localparam int          GND_N = 14;
  localparam int          PRG_N = 8;
  localparam int          SW_N  = 22;

  // Register address codes.
  localparam logic [6:0]  ADDR_GND_SLOW = 7'h19;
  localparam logic [6:0]  ADDR_PRG_DBNC = 7'h1a;
  localparam logic [6:0]  ADDR_GND_DBNC = 7'h1b;
  localparam logic [6:0]  ADDR_SLEEP    = 7'h1c;
  localparam logic [6:0]  ADDR_STATUS   = 7'h1f;

  // Reset values of the configuration registers.
  localparam logic [13:0] GND_RST = 14'h0000;
  localparam logic [7:0]  PRG_RST = 8'h00;

  // Slow polling divides the poll rate by four.
  localparam int          SLOW_DIV_W = 2;
  localparam logic [1:0]  SLOW_PHASE = 2'h0;

  // Debounce extension time and its length in clock cycles.
  localparam int          CLK_MHZ      = 250;
  localparam int          DBNC_US      = 1200;
  localparam int          DBNC_CYC     = DBNC_US * CLK_MHZ;
  localparam int          DBNC_W       = 20;
endpackage

// File: hdl/ssp_sleep_cfg.sv
`timescale 1ns/1ns
// What this block does
// - Frame: address bits 31-25, read/write bit 24, data bits 23-0.
// - Slow-poll bit 1 polls a ground input at one quarter rate.
// - Address 0x19 holds ground-input slow-poll bits from data bit 0.
// - Debounce bit 0 detects change by voltage difference, no extension.
// - Debounce bit 1 keeps polling current 1.2 ms longer, samples at end.
// - Extension applies only in sleep and only to inputs with bit set.
// - Address 0x1a holds the eight programmable-input debounce bits.
// - Address 0x1b holds ground-input debounce bits from data bit 0.
// - Sleep is entered only by the dedicated command.
// - Entry command: address 0x1c, write flag 1, all data zero.
// - Accepted entry starts sleep polling and the interrupt timer.
// - Configuration survives a sleep stay and the return to normal.
// - First response after wake shows both flags set and input states.
// - Every response carries the fault and interrupt flags.
// - Reading switch status clears the interrupt-pending flag.
module ssp_sleep_cfg
  import ssp_pkg::*;
#(
  parameter int P_DBNC_CYC = ssp_pkg::DBNC_CYC
) (
  input  wire logic                        i_clk,
  input  wire logic                        i_sys_rst,
  input  wire logic                        i_spi_sclk,
  input  wire logic                        i_spi_cs_n,
  input  wire logic                        i_spi_mosi,
  output logic                             o_spi_miso,
  output logic                             o_spi_miso_oe,
  input  wire logic                        i_fault_any,
  input  wire logic                        i_int_pending,
  input  wire logic [ssp_pkg::SW_N-1:0]    i_switch_state,
  input  wire logic                        i_wake,
  input  wire logic                        i_poll_tick,
  input  wire logic                        i_poll_done,
  output logic                             o_sleep_entry,
  output logic                             o_sleep_state,
  output logic                             o_int_clear,
  output logic [ssp_pkg::GND_N-1:0]        o_ground_slow_poll,
  output logic [ssp_pkg::PRG_N-1:0]        o_prog_wake_debounce,
  output logic [ssp_pkg::GND_N-1:0]        o_ground_wake_debounce,
  output logic [ssp_pkg::GND_N-1:0]        o_ground_poll_en,
  output logic [ssp_pkg::GND_N-1:0]        o_ground_extend,
  output logic [ssp_pkg::PRG_N-1:0]        o_prog_extend,
  output logic                             o_debounce_hold,
  output logic                             o_debounce_sample
);
  import ssp_pkg::*;

  // Elaboration check: the debounce counter must be able to hold the loaded count.
  if (P_DBNC_CYC < 1 || P_DBNC_CYC >= (1 << DBNC_W)) begin : g_bad_dbnc
    $error("P_DBNC_CYC out of range");
  end

  localparam logic [DBNC_W-1:0] DBNC_LOAD = DBNC_W'(P_DBNC_CYC - 1);

  logic [2:0]            sync_w;
  logic                  sclk_s;
  logic                  cs_s;
  logic                  mosi_s;
  logic                  sclk_d_ff;
  logic                  cs_d_ff;
  logic [FRAME_BITS-1:0] rx_ff;
  logic [FRAME_BITS-1:0] tx_ff;
  logic [FRAME_BITS-1:0] resp_ff;
  logic                  resp_load_ff;
  logic [CNT_W-1:0]      bit_cnt_ff;
  logic                  miso_oe_ff;
  logic [GND_N-1:0]      gnd_slow_ff;
  logic [PRG_N-1:0]      prg_dbnc_ff;
  logic [GND_N-1:0]      gnd_dbnc_ff;
  logic                  sleep_ff;
  logic                  entry_ff;
  logic                  wake_pend_ff;
  logic                  int_clr_ff;
  logic [SLOW_DIV_W-1:0] poll_cnt_ff;
  logic [GND_N-1:0]      poll_en_ff;
  logic [GND_N-1:0]      gnd_ext_ff;
  logic [PRG_N-1:0]      prg_ext_ff;
  logic                  hold_ff;
  logic                  sample_ff;
  logic [DBNC_W-1:0]     dbnc_cnt_ff;

  logic                  sclk_rise;
  logic                  sclk_fall;
  logic                  cs_fall;
  logic                  cs_rise;
  logic                  frame_done;
  logic [ADDR_W-1:0]     cmd_addr;
  logic                  cmd_wr;
  logic [DATA_W-1:0]     cmd_data;
  logic                  entry_ok;
  logic [REGD_W-1:0]     rd_data;

  ssp_sync #(
    .WIDTH (3)
  ) u_sync (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_async   ({i_spi_sclk, i_spi_cs_n, i_spi_mosi}),
    .o_sync    (sync_w)
  );

  // Edge detection on the synchronised link signals.
  assign sclk_s    = sync_w[2];
  assign cs_s      = sync_w[1];
  assign mosi_s    = sync_w[0];
  assign sclk_rise = sclk_s & ~sclk_d_ff;
  assign sclk_fall = ~sclk_s & sclk_d_ff;
  assign cs_fall   = ~cs_s & cs_d_ff;
  assign cs_rise   = cs_s & ~cs_d_ff;

  // A frame counts only with exactly 32 clocks; anything else is dropped.
  assign frame_done = cs_rise && (bit_cnt_ff == FRAME_CNT);
  assign cmd_addr   = rx_ff[ADDR_MSB:ADDR_LSB];
  assign cmd_wr     = rx_ff[RW_BIT];
  assign cmd_data   = rx_ff[DATA_W-1:0];
  assign entry_ok   = frame_done && cmd_addr == ADDR_SLEEP && cmd_wr
                      && cmd_data == '0;

  // Read data for the response; unmapped and write-only codes read as zero.
  always_comb begin
    rd_data = '0;
    case (cmd_addr)
      ADDR_GND_SLOW: rd_data = REGD_W'(gnd_slow_ff);
      ADDR_PRG_DBNC: rd_data = REGD_W'(prg_dbnc_ff);
      ADDR_GND_DBNC: rd_data = REGD_W'(gnd_dbnc_ff);
      ADDR_STATUS:   rd_data = i_switch_state;
      default:       rd_data = '0;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      sclk_d_ff <= 1'b1;
      cs_d_ff   <= 1'b1;
    end else begin
      sclk_d_ff <= sclk_s;
      cs_d_ff   <= cs_s;
    end
  end

  // Receive shift register: MOSI is taken on the rising link clock edge.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rx_ff      <= '0;
      bit_cnt_ff <= '0;
    end else if (cs_fall) begin
      bit_cnt_ff <= '0;
    end else if (sclk_rise && !cs_s) begin
      rx_ff <= {rx_ff[FRAME_BITS-2:0], mosi_s};
      // Saturate well past 32 so that an over-long frame never looks whole.
      if (bit_cnt_ff != '1) begin
        bit_cnt_ff <= bit_cnt_ff + 1'b1;
      end
    end
  end

  // The answer to a command goes out in the frame that follows it.
  // It is captured one clock after the frame, so a write answers with the value it stored.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      resp_load_ff <= 1'b0;
      resp_ff      <= '0;
    end else begin
      resp_load_ff <= frame_done;
      if (resp_load_ff) begin
        resp_ff <= {cmd_addr, cmd_wr, i_fault_any, i_int_pending, rd_data};
      end
    end
  end

  // Transmit: load at chip select fall, shift on each falling link edge.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      tx_ff <= '0;
    end else if (cs_fall) begin
      if (wake_pend_ff) begin
        tx_ff <= {ADDR_STATUS, 1'b0, 1'b1, 1'b1, i_switch_state};
      end else begin
        tx_ff <= resp_ff;
      end
    end else if (sclk_fall && !cs_s) begin
      tx_ff <= {tx_ff[FRAME_BITS-2:0], 1'b0};
    end
  end

  // MISO is driven only while the device is selected.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      miso_oe_ff <= 1'b0;
    end else begin
      miso_oe_ff <= ~cs_s;
    end
  end

  // Configuration writes; sleep never touches these registers.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      gnd_slow_ff <= GND_RST;
      prg_dbnc_ff <= PRG_RST;
      gnd_dbnc_ff <= GND_RST;
    end else if (frame_done && cmd_wr) begin
      if (cmd_addr == ADDR_GND_SLOW) begin
        gnd_slow_ff <= cmd_data[GND_N-1:0];
      end
      if (cmd_addr == ADDR_PRG_DBNC) begin
        prg_dbnc_ff <= cmd_data[PRG_N-1:0];
      end
      if (cmd_addr == ADDR_GND_DBNC) begin
        gnd_dbnc_ff <= cmd_data[GND_N-1:0];
      end
    end
  end

  // Sleep state: set only by the entry command, cleared by a wake event.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      sleep_ff <= 1'b0;
      entry_ff <= 1'b0;
    end else begin
      entry_ff <= entry_ok && !sleep_ff;
      if (entry_ok) begin
        sleep_ff <= 1'b1;
      end else if (i_wake) begin
        sleep_ff <= 1'b0;
      end
    end
  end

  // Wake marker for the next response; a new wake wins over the clear.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      wake_pend_ff <= 1'b0;
    end else if (i_wake && sleep_ff) begin
      wake_pend_ff <= 1'b1;
    end else if (cs_fall) begin
      wake_pend_ff <= 1'b0;
    end
  end

  // Status read asks the interrupt logic to drop its pending flag.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      int_clr_ff <= 1'b0;
    end else begin
      int_clr_ff <= frame_done && cmd_addr == ADDR_STATUS && !cmd_wr;
    end
  end

  // Poll phase counter, running on poll ticks during sleep only.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      poll_cnt_ff <= SLOW_PHASE;
    end else if (!sleep_ff) begin
      poll_cnt_ff <= SLOW_PHASE;
    end else if (i_poll_tick) begin
      poll_cnt_ff <= poll_cnt_ff + 1'b1;
    end
  end

  // Slow inputs poll on one tick in four, so their period is four times longer.
  for (genvar g = 0; g < GND_N; g++) begin : g_poll
    always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
        poll_en_ff[g] <= 1'b0;
      end else begin
        poll_en_ff[g] <= sleep_ff && i_poll_tick
                         && (!gnd_slow_ff[g] || poll_cnt_ff == SLOW_PHASE);
      end
    end
  end

  // Extension masks: only in sleep, only where the debounce bit is set.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      gnd_ext_ff <= '0;
      prg_ext_ff <= '0;
    end else begin
      gnd_ext_ff <= sleep_ff ? gnd_dbnc_ff : '0;
      prg_ext_ff <= sleep_ff ? prg_dbnc_ff : '0;
    end
  end

  // Debounce timer holds the polling current, then asks for one sample.
  // One shared timer is enough because slow inputs poll on a subset of the same poll ticks.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      hold_ff     <= 1'b0;
      sample_ff   <= 1'b0;
      dbnc_cnt_ff <= '0;
    end else begin
      sample_ff <= 1'b0;
      if (!sleep_ff) begin
        hold_ff <= 1'b0;
      end else if (!hold_ff && i_poll_done && (|gnd_ext_ff || |prg_ext_ff)) begin
        hold_ff     <= 1'b1;
        dbnc_cnt_ff <= DBNC_LOAD;
      end else if (hold_ff) begin
        if (dbnc_cnt_ff == '0) begin
          hold_ff   <= 1'b0;
          sample_ff <= 1'b1;
        end else begin
          dbnc_cnt_ff <= dbnc_cnt_ff - 1'b1;
        end
      end
    end
  end

  assign o_spi_miso             = tx_ff[FRAME_BITS-1];
  assign o_spi_miso_oe          = miso_oe_ff;
  assign o_sleep_entry          = entry_ff;
  assign o_sleep_state          = sleep_ff;
  assign o_int_clear            = int_clr_ff;
  assign o_ground_slow_poll     = gnd_slow_ff;
  assign o_prog_wake_debounce   = prg_dbnc_ff;
  assign o_ground_wake_debounce = gnd_dbnc_ff;
  assign o_ground_poll_en       = poll_en_ff;
  assign o_ground_extend        = gnd_ext_ff;
  assign o_prog_extend          = prg_ext_ff;
  assign o_debounce_hold        = hold_ff;
  assign o_debounce_sample      = sample_ff;

  a_reset_clears_cfg: assert property (@(posedge i_clk)
    $past(i_sys_rst) |-> (gnd_slow_ff == '0 && prg_dbnc_ff == '0 && gnd_dbnc_ff == '0))
    else $error("config not cleared by reset");

  a_slow_write: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    frame_done && cmd_wr && cmd_addr == ADDR_GND_SLOW |=> gnd_slow_ff == $past(cmd_data[13:0]))
    else $error("slow poll write lost");

  a_prog_dbnc_write: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    frame_done && cmd_wr && cmd_addr == ADDR_PRG_DBNC |=> prg_dbnc_ff == $past(cmd_data[7:0]))
    else $error("programmable debounce write lost");

  a_gnd_dbnc_write: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    frame_done && cmd_wr && cmd_addr == ADDR_GND_DBNC |=> gnd_dbnc_ff == $past(cmd_data[13:0]))
    else $error("ground debounce write lost");

  a_sleep_by_cmd: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $rose(sleep_ff) |-> $past(frame_done && cmd_wr && cmd_addr == ADDR_SLEEP && cmd_data == '0))
    else $error("sleep entered without command");

  a_cfg_kept: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $fell(sleep_ff) |-> $stable(gnd_slow_ff) && $stable(prg_dbnc_ff) && $stable(gnd_dbnc_ff))
    else $error("config changed across sleep");

  a_wake_flags: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    wake_pend_ff && cs_fall |=> tx_ff[FAULT_BIT] && tx_ff[INT_BIT] && !wake_pend_ff)
    else $error("wake response flags missing");

  a_int_clear: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    frame_done && !cmd_wr && cmd_addr == ADDR_STATUS |=> o_int_clear ##1 !o_int_clear)
    else $error("status read did not clear interrupt");

  a_extend_sleep: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (|o_ground_extend || |o_prog_extend) |-> $past(sleep_ff))
    else $error("extension outside sleep");

  a_slow_quarter: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    poll_en_ff[0] && gnd_slow_ff[0] && $stable(gnd_slow_ff) |-> $past(poll_cnt_ff) == SLOW_PHASE)
    else $error("slow input polled off phase");

  a_sample_end: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_debounce_sample |-> $past(hold_ff) && !hold_ff)
    else $error("sample without hold");
endmodule // ssp_sleep_cfg

// File: hdl/ssp_sync.sv
`timescale 1ns/1ns
// Two-stage synchroniser for pin inputs; only the second stage is read.
module ssp_sync #(
  parameter int WIDTH = 3
) (
  input  wire logic             i_clk,
  input  wire logic             i_sys_rst,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // Reset values put the link at idle with chip select high.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      meta_ff <= '1;
      sync_ff <= '1;
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;
endmodule // ssp_sync

// File: sim/ssp_spi_master.sv
`timescale 1ns/1ns
// Model of the microcontroller that masters the serial link to the block.
module ssp_spi_master (
  input  wire logic i_clk,
  input  wire logic i_miso,
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_mosi
);
  // The link clock idles low and data idles at the inverse of its last bit.
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end

  // One frame of nb bits, most significant first; 32 makes a whole command.
  // Each half period is ten system cycles, giving an 80 ns link clock.
  task automatic xfer(input logic [31:0] tx, input int nb, output logic [31:0] rx);
    logic [31:0] sh;
    sh = tx;
    rx = '0;
    @(posedge i_clk);
    o_cs_n <= 1'b0;
    o_mosi <= sh[31];
    for (int i = 0; i < nb; i++) begin
      repeat (10) @(posedge i_clk);
      o_sclk <= 1'b1;
      rx = {rx[30:0], i_miso};
      sh = sh << 1;
      repeat (10) @(posedge i_clk);
      o_sclk <= 1'b0;
      o_mosi <= sh[31];
    end
    repeat (10) @(posedge i_clk);
    o_cs_n <= 1'b1;
    o_mosi <= ~o_mosi;
    repeat (10) @(posedge i_clk);
  endtask
endmodule // ssp_spi_master

// File: sim/test_sleep_poll_config_and_entry.sv
`timescale 1ns/1ns
// Self-checking bench for the sleep polling configuration and entry block.
module test_sleep_poll_config_and_entry;
  import ssp_pkg::*;
  localparam int          DBNC_SIM = 20;
  localparam logic [21:0] SW_PAT   = 22'h2a5c3f;
  logic        i_clk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic [2:0]  pls = 3'h0;
  logic        sclk, cs_n, mosi, miso, miso_oe, miso_w;
  logic        o_sleep_entry, o_sleep_state, o_int_clear, o_debounce_hold, o_debounce_sample;
  logic [13:0] o_ground_slow_poll, o_ground_wake_debounce, o_ground_poll_en, o_ground_extend;
  logic [7:0]  o_prog_wake_debounce, o_prog_extend;
  logic [31:0] exp_rsp;
  logic        exp_ok = 1'b0;
  logic        fault_any = 1'b1;
  logic        int_pend = 1'b0;
  int          n_fail, samples_checked, n_entry, n_clear, n_slow, n_norm, n_hold, n_sample;

  // A released response line shows the inverse of its value, never a stale level.
  assign miso_w = miso_oe ? miso : ~miso;

  initial begin
    forever #2 i_clk = ~i_clk;
  end

  ssp_sleep_cfg #(.P_DBNC_CYC(DBNC_SIM)) ssp_sleep_cfg_i (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_spi_sclk(sclk), .i_spi_cs_n(cs_n),
    .i_spi_mosi(mosi), .o_spi_miso(miso), .o_spi_miso_oe(miso_oe), .i_fault_any(fault_any),
    .i_int_pending(int_pend), .i_switch_state(SW_PAT), .i_wake(pls[0]), .i_poll_tick(pls[1]),
    .i_poll_done(pls[2]), .o_sleep_entry(o_sleep_entry), .o_sleep_state(o_sleep_state),
    .o_int_clear(o_int_clear), .o_ground_slow_poll(o_ground_slow_poll),
    .o_prog_wake_debounce(o_prog_wake_debounce),
    .o_ground_wake_debounce(o_ground_wake_debounce), .o_ground_poll_en(o_ground_poll_en),
    .o_ground_extend(o_ground_extend), .o_prog_extend(o_prog_extend),
    .o_debounce_hold(o_debounce_hold), .o_debounce_sample(o_debounce_sample));

  ssp_spi_master ssp_spi_master_i (
    .i_clk(i_clk), .i_miso(miso_w), .o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi));

  // Pulse and level counters, so single-cycle outputs are never missed.
  always @(posedge i_clk) begin
    n_entry  += (o_sleep_entry === 1'b1);
    n_clear  += (o_int_clear === 1'b1);
    n_slow   += (o_ground_poll_en[0] === 1'b1);
    n_norm   += (o_ground_poll_en[1] === 1'b1);
    n_hold   += (o_debounce_hold === 1'b1);
    n_sample += (o_debounce_sample === 1'b1);
  end

  task automatic check(input logic [39:0] seen, input logic [39:0] expv);
    samples_checked++;
    if (seen !== expv) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask

  // Expected response word with the fault flag high and the interrupt flag low.
  function automatic logic [31:0] rsp(input logic [6:0] a, input logic rw, input logic [21:0] d);
    return {a, rw, 1'b1, 1'b0, d};
  endfunction

  // A frame returns the answer to the one before, so a 32-bit frame checks its predecessor when that answer is marked expected.
  task automatic frame(input logic [6:0] a, input logic rw, input logic [23:0] d, input int nb,
                       input logic [31:0] nxt, input logic nxt_ok);
    logic [31:0] rx;
    ssp_spi_master_i.xfer({a, rw, d}, nb, rx);
    if (exp_ok && nb == 32) begin
      check({8'h00, rx}, {8'h00, exp_rsp});
    end
    exp_rsp = nxt;
    exp_ok  = nxt_ok;
  endtask

  task automatic kick(input int k);
    @(posedge i_clk);
    pls[k] <= 1'b1;
    @(posedge i_clk);
    pls[k] <= 1'b0;
  endtask

  task automatic cfg_out(input logic [13:0] s, input logic [7:0] p, input logic [13:0] g);
    check({4'h0, o_ground_slow_poll, o_prog_wake_debounce, o_ground_wake_debounce},
          {4'h0, s, p, g});
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Watchdog sized well above the roughly 11000 cycles the tests need.
  initial begin
    repeat (60000) @(posedge i_clk);
    n_fail++;
    results();
  end

  initial begin
    repeat (4) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    repeat (6) @(posedge i_clk);
    cfg_out(14'h0, 8'h0, 14'h0);
    check({38'h0, o_sleep_state, miso_oe}, 40'h0);
    frame(ADDR_GND_SLOW, 1'b0, 24'h0, 32, rsp(ADDR_GND_SLOW, 1'b0, 22'h0), 1'b1);
    frame(ADDR_PRG_DBNC, 1'b0, 24'h0, 32, rsp(ADDR_PRG_DBNC, 1'b0, 22'h0), 1'b1);
    frame(ADDR_GND_DBNC, 1'b0, 24'h0, 32, rsp(ADDR_GND_DBNC, 1'b0, 22'h0), 1'b1);
    $display("test reset values done");

    frame(ADDR_GND_SLOW, 1'b1, 24'h003ffd, 32, rsp(ADDR_GND_SLOW, 1'b1, 22'h3ffd), 1'b1);
    int_pend <= 1'b1;
    frame(7'h05, 1'b1, 24'h00ffff, 32, {7'h05, 1'b1, 1'b1, 1'b1, 22'h0}, 1'b1);
    int_pend <= 1'b0;
    frame(ADDR_GND_SLOW, 1'b0, 24'h0, 32, rsp(ADDR_GND_SLOW, 1'b0, 22'h3ffd), 1'b1);
    cfg_out(14'h3ffd, 8'h0, 14'h0);
    check({18'h0, o_ground_extend, o_prog_extend}, 40'h0);
    $display("test configuration writes done");

    frame(ADDR_SLEEP, 1'b0, 24'h0, 32, 32'h0, 1'b0);
    frame(ADDR_SLEEP, 1'b1, 24'h000001, 32, 32'h0, 1'b0);
    frame(ADDR_SLEEP, 1'b1, 24'h0, 31, 32'h0, 1'b0);
    frame(7'h0e, 1'b0, 24'h800000, 33, 32'h0, 1'b0);
    check({39'h0, o_sleep_state}, 40'h0);
    check(40'(n_entry), 40'h0);
    $display("test refused entry done");

    frame(ADDR_SLEEP, 1'b1, 24'h0, 32, 32'h0, 1'b0);
    check({39'h0, o_sleep_state}, 40'h1);
    frame(ADDR_SLEEP, 1'b1, 24'h0, 32, 32'h0, 1'b0);
    check(40'(n_entry), 40'h1);
    repeat (8) kick(1);
    repeat (4) @(posedge i_clk);
    check({8'(n_slow), 8'(n_norm)}, {8'h2, 8'h8});
    kick(2);
    repeat (30) @(posedge i_clk);
    check({8'(n_hold), 8'(n_sample)}, 40'h0);
    $display("test sleep polling done");

    kick(0);
    repeat (3) @(posedge i_clk);
    check({39'h0, o_sleep_state}, 40'h0);
    exp_rsp = {ADDR_STATUS, 1'b0, 1'b1, 1'b1, SW_PAT};
    exp_ok  = 1'b1;
    frame(ADDR_PRG_DBNC, 1'b1, 24'h0000a5, 32, rsp(ADDR_PRG_DBNC, 1'b1, 22'ha5), 1'b1);
    cfg_out(14'h3ffd, 8'ha5, 14'h0);
    frame(ADDR_GND_DBNC, 1'b1, 24'h002aaa, 32, rsp(ADDR_GND_DBNC, 1'b1, 22'h2aaa), 1'b1);
    frame(ADDR_SLEEP, 1'b1, 24'h0, 32, 32'h0, 1'b0);
    cfg_out(14'h3ffd, 8'ha5, 14'h2aaa);
    check({18'h0, o_ground_extend, o_prog_extend}, {18'h0, 14'h2aaa, 8'ha5});
    kick(2);
    repeat (40) @(posedge i_clk);
    check({8'(n_hold), 8'(n_sample)}, {8'(DBNC_SIM), 8'h1});
    $display("test wake debounce done");

    fault_any <= 1'b0;
    kick(0);
    repeat (3) @(posedge i_clk);
    exp_rsp = {ADDR_STATUS, 1'b0, 1'b1, 1'b1, SW_PAT};
    exp_ok  = 1'b1;
    frame(ADDR_STATUS, 1'b0, 24'h0, 32, {ADDR_STATUS, 1'b0, 1'b0, 1'b0, SW_PAT}, 1'b1);
    fault_any <= 1'b1;
    check(40'(n_clear), 40'h1);
    frame(ADDR_GND_SLOW, 1'b0, 24'h0, 32, 32'h0, 1'b0);
    cfg_out(14'h3ffd, 8'ha5, 14'h2aaa);
    check({18'h0, o_ground_extend, o_prog_extend}, 40'h0);
    $display("test wake response done");
    results();
  end
endmodule // test_sleep_poll_config_and_entry
